// ### hdl/sbs_consts.vh
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
// ==========================================
// array geometry
`define SBS_ADDR_W 18
`define SBS_DATA_W 72
`define SBS_LANES 8
`define SBS_LANE_W 9
`define SBS_BURST_W 2
// ==========================================
// mode encodings
`define SBS_ORDER_LINEAR 1'b0
`define SBS_DESEL_SINGLE 1'b1
`define SBS_BURST_ONE 2'h1
`define SBS_BURST_ZERO 2'h0
`endif

// ### hdl/sbs_burst_counter.v
`timescale 1ns/1ns
`include "sbs_consts.vh"
// ==========================================
// burst address counter, presets from low address bits
module sbs_burst_counter #(
  parameter W = `SBS_BURST_W
) (
  input wire ref_clk,
  input wire rst_n,
  input wire load,
  input wire advance,
  input wire order_linear,
  input wire [W-1:0] start,
  output wire [W-1:0] addr_low
);
  reg [W-1:0] base;
  reg [W-1:0] beat;
  wire [W-1:0] cur_beat;
  wire [W-1:0] next_beat;
  // an advance cycle already addresses the stepped beat, not the old one
  assign cur_beat = advance ? beat + `SBS_BURST_ONE : beat;
  assign next_beat = load ? `SBS_BURST_ZERO : cur_beat;
  // linear adds the beat count, interleaved xors it
  assign addr_low = order_linear ? base + cur_beat : base ^ cur_beat;
  // counter steps only on advance, wraps modulo four
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base <= `SBS_BURST_ZERO;
      beat <= `SBS_BURST_ZERO;
    end else if (load) begin
      base <= start;
      beat <= next_beat;
    end else if (advance) begin
      beat <= next_beat;
    end
  end
endmodule

// ### hdl/sbs_lane_ram.v
`timescale 1ns/1ns
`include "sbs_consts.vh"
// ==========================================
// one byte lane of storage with registered read
module sbs_lane_ram #(
  parameter AW = `SBS_ADDR_W,
  parameter DW = `SBS_LANE_W
) (
  input wire ref_clk,
  input wire we,
  input wire re,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // write completes in its own cycle, no extra control needed
  always @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end
endmodule

// ### hdl/sbs_sram_port.v
`timescale 1ns/1ns
`include "sbs_consts.vh"
module sbs_sram_port #(
  parameter AW = `SBS_ADDR_W,
  parameter DW = `SBS_DATA_W,
  parameter LANES = `SBS_LANES,
  parameter LW = `SBS_LANE_W
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] data_lane_in,
  output reg [DW-1:0] data_lane_out,
  output wire [DW-1:0] data_lane_oe_n,
  input wire chip_select_n,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire burst_advance_n,
  input wire [LANES-1:0] lane_write_enable_n,
  input wire byte_write_gate_n,
  input wire all_lanes_write_n,
  input wire output_enable_n,
  input wire sleep_request,
  input wire burst_order_select_n,
  input wire deselect_mode_select,
  output reg sleeping
);
  // ==========================================
  // input capture registers
  // pins are sampled by the rising edge itself, as the bus is synchronous
  reg [AW-1:0] cap_addr;
  reg [DW-1:0] cap_data;
  reg cap_cs_n;
  reg cap_padsp_n;
  reg cap_cadsc_n;
  reg cap_adv_n;
  reg [LANES-1:0] cap_lane_n;
  reg cap_bw_n;
  reg cap_gw_n;
  reg ord_sync1;
  reg ord_sync2;
  reg dsl_sync1;
  reg dsl_sync2;
  reg slp_sync1;
  reg slp_sync2;
  reg burst_active;
  reg [AW-`SBS_BURST_W-1:0] burst_hi;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_addr <= {AW{1'b0}};
      cap_data <= {DW{1'b0}};
      cap_cs_n <= 1'b1;
      cap_padsp_n <= 1'b1;
      cap_cadsc_n <= 1'b1;
      cap_adv_n <= 1'b1;
      cap_lane_n <= {LANES{1'b1}};
      cap_bw_n <= 1'b1;
      cap_gw_n <= 1'b1;
    end else begin
      cap_addr <= addr;
      cap_data <= data_lane_in;
      cap_cs_n <= chip_select_n;
      cap_padsp_n <= proc_addr_strobe_n;
      cap_cadsc_n <= ctrl_addr_strobe_n;
      cap_adv_n <= burst_advance_n;
      cap_lane_n <= lane_write_enable_n;
      cap_bw_n <= byte_write_gate_n;
      cap_gw_n <= all_lanes_write_n;
    end
  end

  // ==========================================
  // mode and sleep synchronisers
  // mode pins are static straps; reset values match their pulled defaults
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ord_sync1 <= 1'b1;
      ord_sync2 <= 1'b1;
      dsl_sync1 <= `SBS_DESEL_SINGLE;
      dsl_sync2 <= `SBS_DESEL_SINGLE;
      slp_sync1 <= 1'b0;
      slp_sync2 <= 1'b0;
    end else begin
      ord_sync1 <= burst_order_select_n;
      ord_sync2 <= ord_sync1;
      dsl_sync1 <= deselect_mode_select;
      dsl_sync2 <= dsl_sync1;
      slp_sync1 <= sleep_request;
      slp_sync2 <= slp_sync1;
    end
  end

  // ==========================================
  // cycle decode
  wire order_linear;
  wire dual_cycle_deselect;
  wire start_cycle;
  wire cont_cycle;
  wire access;
  wire write_cyc;
  wire [LANES-1:0] lane_we;
  wire [`SBS_BURST_W-1:0] burst_low;
  wire [AW-1:0] mem_addr;
  wire [DW-1:0] rd_word;

  assign order_linear = (ord_sync2 == `SBS_ORDER_LINEAR);
  assign dual_cycle_deselect = (dsl_sync2 != `SBS_DESEL_SINGLE);
  // a processor strobe while deselected starts nothing but still deselects
  assign start_cycle = !cap_cs_n &&
    (!cap_padsp_n || !cap_cadsc_n);
  assign cont_cycle = cap_padsp_n && cap_cadsc_n && burst_active;
  // a strobe every cycle loads a new address with no gap
  assign access = (start_cycle || cont_cycle) && !slp_sync2;
  // processor strobe start forces a read, as usual for this bus
  assign write_cyc = access && cap_padsp_n &&
    (!cap_gw_n || (!cap_bw_n && !(&cap_lane_n)));
  // global write overrides byte controls
  assign lane_we = !write_cyc ? {LANES{1'b0}} :
    !cap_gw_n ? {LANES{1'b1}} : ~cap_lane_n;

  // burst state: start on any strobe while selected, end on deselect
  // upper address is held so pins may float during a burst
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_active <= 1'b0;
      burst_hi <= {(AW-`SBS_BURST_W){1'b0}};
    end else if (start_cycle) begin
      burst_active <= 1'b1;
      burst_hi <= cap_addr[AW-1:`SBS_BURST_W];
    end else if (cap_cs_n && (!cap_padsp_n || !cap_cadsc_n)) begin
      burst_active <= 1'b0;
    end
  end

  // ==========================================
  // burst counter
  sbs_burst_counter #(
    .W(`SBS_BURST_W)
  ) u_burst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(start_cycle),
    .advance(cont_cycle && !cap_adv_n && !slp_sync2),
    .order_linear(order_linear),
    .start(cap_addr[`SBS_BURST_W-1:0]),
    .addr_low(burst_low)
  );

  // a fresh start uses the captured address directly
  assign mem_addr = start_cycle ? cap_addr :
    {burst_hi, burst_low};

  // ==========================================
  // storage, one instance per lane
  // sleep blocks every write so contents are retained
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      sbs_lane_ram #(
        .AW(AW),
        .DW(LW)
      ) u_lane (
        .ref_clk(ref_clk),
        .we(lane_we[g] && !slp_sync2),
        .re(access && !write_cyc),
        .addr(mem_addr),
        .wdata(cap_data[g*LW +: LW]),
        .rdata(rd_word[g*LW +: LW])
      );
    end
  endgenerate

  // ==========================================
  // output pipeline and deselect timing
  reg rd_stage1;
  reg rd_stage2;
  reg desel_hold;
  reg drive;
  wire desel_now;

  // deselect = any cycle without access (chip disabled with strobe, idle outside a burst, sleep), or a write cycle
  assign desel_now = !access || write_cyc;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_stage1 <= 1'b0;
      rd_stage2 <= 1'b0;
      desel_hold <= 1'b0;
      drive <= 1'b0;
      data_lane_out <= {DW{1'b0}};
      sleeping <= 1'b0;
    end else begin
      rd_stage1 <= access && !write_cyc;
      rd_stage2 <= rd_stage1;
      desel_hold <= desel_now;
      sleeping <= slp_sync2;
      if (rd_stage1) begin
        data_lane_out <= rd_word;
      end
      // single mode drops drive one edge after the deselect capture
      if (!dual_cycle_deselect && desel_now) begin
        drive <= 1'b0;
      end else if (dual_cycle_deselect && desel_now && desel_hold &&
                   !rd_stage1) begin
        drive <= 1'b0;
      end else if (write_cyc) begin
        drive <= 1'b0;
      end else if (rd_stage1) begin
        drive <= 1'b1;
      end
    end
  end

  // output enable and sleep gate the drivers without a clock edge
  assign data_lane_oe_n = {DW{~(drive && !output_enable_n &&
    !sleep_request)}};
endmodule

// ### tb/sbs_sram_port_props.sv
`timescale 1ns/1ns
// ==========================================
// pin-level checks on the sram port
module sbs_props (
  input wire ref_clk,
  input wire rst_n,
  input wire chip_select_n,
  input wire proc_addr_strobe_n,
  input wire ctrl_addr_strobe_n,
  input wire burst_advance_n,
  input wire byte_write_gate_n,
  input wire all_lanes_write_n,
  input wire output_enable_n,
  input wire sleep_request,
  input wire deselect_mode_select,
  input wire [71:0] data_lane_oe_n,
  input wire sleeping
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // access kinds; reads only count when sleep is fully out of the way
  wire stb = !ctrl_addr_strobe_n || !proc_addr_strobe_n;
  wire nwr = all_lanes_write_n && byte_write_gate_n && !sleep_request;
  wire rdn = stb && !chip_select_n && nwr && !sleeping;
  wire rda = !stb && !burst_advance_n && nwr && !sleeping;
  wire wrs = !ctrl_addr_strobe_n && !chip_select_n && !all_lanes_write_n;
  wire dsl = stb && chip_select_n;
  wire off = &data_lane_oe_n;
  sequence rd_two; rdn ##1 rda; endsequence
  sequence dual_gap;
    rd_two ##1 (dsl && !deselect_mode_select) ##1 rdn;
  endsequence
  // ==========================================
  // output drive timing and sleep flag
  read_drive_a: assert property (
    rd_two |-> ##2 (output_enable_n || sleep_request ||
      data_lane_oe_n == 72'h0))
    else $error("read data not driven");
  oe_gate_a: assert property (
    output_enable_n || sleep_request |-> off)
    else $error("lanes driven while disabled");
  write_hiz_a: assert property (wrs |-> ##2 off)
    else $error("lanes driven during write");
  scd_off_a: assert property (
    dsl && deselect_mode_select |-> ##2 off)
    else $error("single deselect left lanes on");
  dcd_off_a: assert property (
    dsl ##1 (dsl && !deselect_mode_select) |-> ##2 off)
    else $error("dual deselect left lanes on");
  dcd_hold_a: assert property (
    dual_gap |-> ##1 (output_enable_n || !off))
    else $error("dual deselect dropped drive early");
  sleep_enter_a: assert property (sleep_request [*5] |-> sleeping)
    else $error("sleep flag not raised");
  sleep_exit_a: assert property (!sleep_request [*5] |-> !sleeping)
    else $error("sleep flag not cleared");
endmodule

// ### tb/sbs_host.sv
`timescale 1ns/1ns
// ==========================================
// host controller model, one bus cycle per call
module sbs_host (
  input wire ref_clk,
  output reg [17:0] addr,
  output reg [71:0] data_lane_in,
  output reg chip_select_n,
  output reg proc_addr_strobe_n,
  output reg ctrl_addr_strobe_n,
  output reg burst_advance_n,
  output reg [7:0] lane_write_enable_n,
  output reg byte_write_gate_n,
  output reg all_lanes_write_n,
  output reg output_enable_n,
  output reg sleep_request,
  output reg burst_order_select_n,
  output reg deselect_mode_select
);
  initial begin
    {addr, data_lane_in, lane_write_enable_n} = {90'h0, 8'hff};
    {chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n} = 3'h7;
    {burst_advance_n, byte_write_gate_n, all_lanes_write_n} = 3'h7;
    {output_enable_n, sleep_request} = 2'h0;
    {burst_order_select_n, deselect_mode_select} = 2'h3;
  end
  // k: 0 idle 1 read 2 proc read 3 advance 4 write 5 lanes 6 deselect
  task cyc(input [2:0] k, input [17:0] a, input [71:0] d, input [7:0] ln);
    begin
      addr = a;
      ctrl_addr_strobe_n = !(k == 1 || k >= 4);
      proc_addr_strobe_n = (k != 2);
      chip_select_n = (k == 6);
      burst_advance_n = (k != 3);
      all_lanes_write_n = (k != 4);
      byte_write_gate_n = (k != 5);
      lane_write_enable_n = ln;
      // unused data lines toggle so a stale value never matches
      data_lane_in = (k == 4 || k == 5) ? d : ~data_lane_in;
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
// ==========================================
// bench top
module tb;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  wire [17:0] addr;
  wire [71:0] data_lane_in, data_lane_out, data_lane_oe_n;
  wire [7:0] lane_write_enable_n;
  wire chip_select_n, proc_addr_strobe_n, ctrl_addr_strobe_n;
  wire burst_advance_n, byte_write_gate_n, all_lanes_write_n;
  wire output_enable_n, sleep_request, burst_order_select_n;
  wire deselect_mode_select, sleeping;
  integer miscompares = 0, tests_run = 0, i, m;
  reg [71:0] mem [0:15];
  reg pv0 = 1'b0, pv1 = 1'b0, pv2 = 1'b0;
  reg [71:0] pd0, pd1, pd2, e;
  sbs_sram_port u_dut (.*);
  sbs_host u_h (.*);
  always #4 ref_clk = ~ref_clk;
  task chk(input [71:0] got, input [71:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // one cycle; refused writes during sleep leave the model alone
  task op(input [2:0] k, input [3:0] a, input [71:0] d, input [7:0] ln);
    integer j;
    begin
      pv0 = (k >= 1 && k <= 3);
      pd0 = mem[a];
      for (j = 0; j < 8; j = j + 1)
        if (!sleep_request && (k == 4 || (k == 5 && !ln[j])))
          mem[a][9*j +: 9] = d[9*j +: 9];
      u_h.cyc(k, {14'h0, a}, d, ln);
    end
  endtask
  // strobe start, then four advances that must wrap to the start
  task burst(input [2:0] k, input [1:0] b, input [1:0] s);
    integer n;
    reg [1:0] w;
    begin
      op(k, {b, s}, 72'h0, 8'hff);
      for (n = 1; n <= 4; n = n + 1) begin
        w = burst_order_select_n ? s ^ n[1:0] : s + n[1:0];
        op(3, {b, w}, 72'h0, 8'hff);
      end
    end
  endtask
  // read data lands two edges after capture
  always @(posedge ref_clk) begin
    {pv2, pd2} <= {pv1, pd1};
    {pv1, pd1} <= {pv0, pd0};
    e = pd2;
    if (pv2) begin
      #1 chk(data_lane_out, e);
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 3; i = i + 1) op(0, 0, 72'h0, 8'hff);
    for (i = 0; i < 16; i = i + 1)
      op(4, i, 72'h3a5c96f1e2d0b4c781 * (i + 1), 8'h5a);
    op(5, 2, ~72'h0, 8'hf6);
    op(5, 6, 72'h0, 8'h7f);
    $display("done writes");
    for (m = 0; m < 2; m = m + 1) begin
      u_h.burst_order_select_n = m;
      u_h.deselect_mode_select = m;
      for (i = 0; i < 3; i = i + 1) op(0, 0, 72'h0, 8'hff);
      burst(1, m, 1);
      burst(2, 2 + m, 3);
      op(1, 8, 72'h0, 8'hff);
      op(3, 9, 72'h0, 8'hff);
      op(6, 0, 72'h0, 8'hff);
      op(1, 12, 72'h0, 8'hff);
      op(6, 0, 72'h0, 8'hff);
      op(6, 0, 72'h0, 8'hff);
      $display("done bursts in mode %0d", m);
    end
    op(1, 4, 72'h0, 8'hff);
    op(3, 5, 72'h0, 8'hff);
    op(3, 6, 72'h0, 8'hff);
    u_h.output_enable_n = 1'b1;
    #1 chk(data_lane_oe_n, ~72'h0);
    u_h.output_enable_n = 1'b0;
    #1 chk(data_lane_oe_n, 72'h0);
    u_h.sleep_request = 1'b1;
    #1 chk(data_lane_oe_n, ~72'h0);
    for (i = 0; i < 6; i = i + 1) op(0, 0, 72'h0, 8'hff);
    chk({71'h0, sleeping}, 72'h1);
    op(4, 0, ~72'h0, 8'hff);
    u_h.sleep_request = 1'b0;
    for (i = 0; i < 6; i = i + 1) op(0, 0, 72'h0, 8'hff);
    chk({71'h0, sleeping}, 72'h0);
    op(1, 0, 72'h0, 8'hff);
    for (i = 0; i < 4; i = i + 1) op(0, 0, 72'h0, 8'hff);
    $display("done sleep");
    close_out;
  end
  // the run needs about 85 cycles; this allows over seventeen times that
  initial begin
    #12000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule
bind sbs_sram_port sbs_props u_p (.*);
